// ===== cedp_loader.sv
// Module: power-on delay, error detection and bit streaming of the configuration memory
`timescale 1ns/1ps
`default_nettype none

// Function
// - Wait an internal power-on delay of at most 200 ms before configuring.
// - Chip-select input senses the target's done line during the whole transfer.
// - Error when done is still low after the last bit is sent.
// - Error when done goes high while bits remain to be sent.
// - On error pull the open-drain output-enable/reset line low.
// - Restart automatically after error only when the auto-restart option bit is set.
// - Target pulling the shared line low resets configuration state.
// - Reprogrammable part: strap low means 5.0-V mode, high means 3.3-V mode.
// - One-time parts choose supply mode from a stored option bit, not a pin.
// - Low reset line clears the bit counter; high enables data and counting.
// - Serial clock rising edge advances counter only when enabled and data remains.
// - Low chip-select lets the serial clock count and enables data output.
module cedp_loader #(
    parameter int unsigned IMAGE_BITS = cedp_pkg::IMAGE_BITS,
    parameter int unsigned POR_CYCLES = cedp_pkg::POR_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic serial_config_clock_i,
    input wire logic done_sense_select_n_i,
    input wire logic oe_line_i,
    input wire logic image_bit_i,
    input wire logic auto_restart_opt_i,
    input wire logic reprogrammable_i,
    input wire logic core_voltage_strap_i,
    input wire logic low_voltage_opt_i,
    input wire logic prog_voltage_strap_i,
    output logic [cedp_pkg::ADDR_W-1:0] bit_addr_o,
    output logic data_o,
    output logic data_oe_n_o,
    output logic oe_line_o,
    output logic oe_line_oe_n_o,
    output logic cascade_select_out_n_o,
    output logic config_error_o,
    output logic supply_mode_o,
    output logic prog_mode_o
);
    localparam int unsigned AW = cedp_pkg::ADDR_W;
    localparam logic [AW-1:0] LAST = AW'(IMAGE_BITS - 1);
    localparam logic [31:0] POR_LAST = 32'(POR_CYCLES - 1);

    if (IMAGE_BITS < 2 || IMAGE_BITS > (1 << AW) || POR_CYCLES < 1
            || POR_CYCLES > cedp_pkg::POR_CYCLES) begin : g_bad_params
        $error("cedp_loader: unsupported parameters");
    end

    // ***********************
    // State
    // ***********************
    typedef struct packed {
        cedp_pkg::cedp_state_t st;
        logic [31:0] por_cnt;
        logic [AW-1:0] addr;
        logic sclk_prev;
        logic data;
        logic data_oe_n;
        logic pull_low;
        logic casc_n;
        logic err;
        logic supply;
        logic prog;
    } cedp_regs_t;

    cedp_regs_t s_q;
    cedp_regs_t s_d;

    // Shared line seen low by the target or by us
    logic line_low;
    logic sclk_rise;
    logic done_hi;
    assign line_low = !oe_line_i;
    assign sclk_rise = serial_config_clock_i && !s_q.sclk_prev;
    assign done_hi = done_sense_select_n_i;

    // ***********************
    // Next state
    // ***********************
    always_comb begin
        s_d = s_q;
        s_d.sclk_prev = serial_config_clock_i;
        // Mode follows strap or stored bit
        s_d.supply = reprogrammable_i ? core_voltage_strap_i : low_voltage_opt_i;
        s_d.prog = prog_voltage_strap_i ? cedp_pkg::MODE_3V3 : cedp_pkg::MODE_5V0;
        case (s_q.st)
            cedp_pkg::CEDP_POR: begin
                s_d.pull_low = 1'b1;
                s_d.data_oe_n = 1'b1;
                s_d.por_cnt = s_q.por_cnt + 32'h1;
                if (s_q.por_cnt >= POR_LAST) begin
                    s_d.pull_low = 1'b0;
                    s_d.st = cedp_pkg::CEDP_IDLE;
                end
            end
            cedp_pkg::CEDP_IDLE, cedp_pkg::CEDP_STREAM: begin
                if (line_low) begin
                    // Counter cleared; stream restarts from bit zero
                    s_d.addr = '0;
                    s_d.data_oe_n = 1'b1;
                    s_d.casc_n = 1'b1;
                    s_d.st = cedp_pkg::CEDP_IDLE;
                end else if (done_hi && s_q.st == cedp_pkg::CEDP_STREAM) begin
                    s_d.err = 1'b1;
                    s_d.pull_low = 1'b1;
                    s_d.data_oe_n = 1'b1;
                    s_d.st = cedp_pkg::CEDP_ERROR;
                end else if (!done_hi) begin
                    s_d.data_oe_n = 1'b0;
                    s_d.data = image_bit_i;
                    s_d.st = cedp_pkg::CEDP_STREAM;
                    if (sclk_rise) begin
                        if (s_q.addr == LAST) begin
                            s_d.casc_n = 1'b0;
                            s_d.data_oe_n = 1'b1;
                            s_d.st = cedp_pkg::CEDP_DONE;
                        end else begin
                            s_d.addr = s_q.addr + AW'(1);
                        end
                    end
                end
            end
            cedp_pkg::CEDP_DONE: begin
                s_d.data_oe_n = 1'b1;
                if (line_low) begin
                    s_d.addr = '0;
                    s_d.casc_n = 1'b1;
                    s_d.st = cedp_pkg::CEDP_IDLE;
                end else if (!done_hi) begin
                    s_d.err = 1'b1;
                    s_d.pull_low = 1'b1;
                    s_d.st = cedp_pkg::CEDP_ERROR;
                end
            end
            cedp_pkg::CEDP_ERROR: begin
                s_d.data_oe_n = 1'b1;
                s_d.addr = '0;
                s_d.casc_n = 1'b1;
                if (auto_restart_opt_i) begin
                    s_d.pull_low = 1'b0;
                    s_d.err = 1'b0;
                    s_d.st = cedp_pkg::CEDP_IDLE;
                end
            end
            default: s_d.st = cedp_pkg::CEDP_POR;
        endcase
    end

    // ***********************
    // Registers
    // ***********************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.st <= cedp_pkg::CEDP_POR;
            s_q.data_oe_n <= 1'b1;
            s_q.pull_low <= 1'b1;
            s_q.casc_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ***********************
    // Outputs
    // ***********************
    assign bit_addr_o = s_q.addr;
    assign data_o = s_q.data;
    assign data_oe_n_o = s_q.data_oe_n;
    assign oe_line_o = 1'b0;
    // Open drain: enable low drives the line low
    assign oe_line_oe_n_o = !s_q.pull_low;
    assign cascade_select_out_n_o = s_q.casc_n;
    assign config_error_o = s_q.err;
    assign supply_mode_o = s_q.supply;
    assign prog_mode_o = s_q.prog;

    // ***********************
    // Assertions
    // ***********************
    a_por_release: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == cedp_pkg::CEDP_POR) |-> s_q.por_cnt <= POR_LAST)
        else $error("power-on delay overran");
    a_por_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == cedp_pkg::CEDP_POR && s_q.por_cnt == POR_LAST) |=> oe_line_oe_n_o)
        else $error("line not released after power-on delay");
    a_early_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == cedp_pkg::CEDP_STREAM && oe_line_i && done_hi) |=> s_q.err)
        else $error("early done not flagged");
    a_late_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == cedp_pkg::CEDP_DONE && oe_line_i && !done_hi) |=> s_q.err)
        else $error("missing done not flagged");
    a_err_pull: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(s_q.err) |-> !oe_line_oe_n_o)
        else $error("error without line pull");
    a_no_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.err && !auto_restart_opt_i) |=> s_q.err)
        else $error("restart without option");
    a_restart_fresh: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.st == cedp_pkg::CEDP_ERROR && auto_restart_opt_i) |=> s_q.addr == '0 && !s_q.err)
        else $error("restart not from first bit");
    a_line_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (!oe_line_i && s_q.st != cedp_pkg::CEDP_POR && s_q.st != cedp_pkg::CEDP_ERROR)
        |=> s_q.addr == '0)
        else $error("counter not cleared");
    a_count_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_q.addr != $past(s_q.addr) && s_q.addr != '0)
        |-> $past(sclk_rise && oe_line_i && !done_hi))
        else $error("counter moved without enable");
    a_err_tristate: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.err |-> data_oe_n_o)
        else $error("data driven during error");
    a_supply_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        reprogrammable_i |=> supply_mode_o == $past(core_voltage_strap_i))
        else $error("supply mode not from strap");
    a_otp_mode: assert property (@(posedge clk_i) disable iff (rst_i)
        !reprogrammable_i |=> supply_mode_o == $past(low_voltage_opt_i))
        else $error("supply mode not from stored bit");
endmodule // cedp_loader

`default_nettype wire

// ===== cedp_loader_bench.sv
// Testbench of the configuration loader with a target model
`timescale 1ns/1ps
`default_nettype none
module cedp_loader_bench;
    logic clk = 0, rst = 1, clr = 1, run = 0, pull_n = 1, auto = 0, mon = 0;
    logic rep = 0, core = 0, lowv = 0, prog = 0, sclk, done, line, dat, doe_n, od, od_n;
    logic casc_n, err, smode, pmode;
    logic [7:0] done_at = 8'h10;
    logic [19:0] addr, rises;
    logic [31:0] r = 32'hc11b;
    int fails = 0, check_count = 0, cyc_n = 0;
    always #5 clk = !clk;
    // Open-drain line with pull-up, target may pull it too
    assign line = (od_n ? 1'h1 : od) & pull_n;
    cedp_loader #(.IMAGE_BITS(16), .POR_CYCLES(20)) u_cedp_loader (.clk_i(clk), .rst_i(rst),
        .serial_config_clock_i(sclk), .done_sense_select_n_i(done), .oe_line_i(line),
        .image_bit_i(img(addr)), .auto_restart_opt_i(auto), .reprogrammable_i(rep),
        .core_voltage_strap_i(core), .low_voltage_opt_i(lowv), .prog_voltage_strap_i(prog),
        .bit_addr_o(addr), .data_o(dat), .data_oe_n_o(doe_n), .oe_line_o(od),
        .oe_line_oe_n_o(od_n), .cascade_select_out_n_o(casc_n), .config_error_o(err),
        .supply_mode_o(smode), .prog_mode_o(pmode));
    cedp_target u_cedp_target (.clk_i(clk), .clr_i(clr), .run_i(run), .done_at_i(done_at),
        .sclk_o(sclk), .done_o(done), .rises_o(rises));
    function automatic logic img(logic [19:0] a);
        return a[0] ^ a[2] ^ a[4];
    endfunction
    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(logic [19:0] got, logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_on(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'h1; i++) @(posedge clk);
        chk(s, 1'h1);
    endtask
    task automatic restart(logic [7:0] at);
        rst <= 1;
        clr <= 1;
        done_at <= at;
        cyc(2);
        rst <= 0;
        clr <= 0;
        cyc(15);
        wait_on(od_n, 12);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Mid-stream: address follows counted rises, data follows the image
    always @(negedge clk) begin
        if (mon && !doe_n && !sclk) begin
            chk(addr, rises);
            chk(dat, img(addr));
        end
    end
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n > 4000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        cyc(12);
        rst <= 0;
        clr <= 0;
        @(negedge clk);
        chk(od_n, 0);
        chk(doe_n, 1);
        cyc(15);
        wait_on(od_n, 12);
        cyc(2);
        chk(doe_n, 0);
        chk(addr, 0);
        $display("test power-on done");
        mon <= 1;
        run <= 1;
        wait_on(casc_n, 0);
        for (int i = 0; i < 300 && casc_n !== 1'h0; i++) @(posedge clk);
        chk(casc_n, 0);
        cyc(12);
        chk(err, 0);
        chk(doe_n, 1);
        mon <= 0;
        run <= 0;
        $display("test good load done");
        restart(8'hff);
        run <= 1;
        wait_on(err, 300);
        chk(od_n, 0);
        chk(doe_n, 1);
        run <= 0;
        cyc(30);
        chk(err, 1);
        $display("test late done done");
        auto <= 1;
        restart(8'h08);
        run <= 1;
        wait_on(err, 200);
        run <= 0;
        clr <= 1;
        wait_on(od_n, 20);
        cyc(2);
        chk(addr, 0);
        chk(doe_n, 0);
        $display("test early done done");
        clr <= 0;
        done_at <= 8'h10;
        run <= 1;
        cyc(40);
        pull_n <= 0;
        cyc(3);
        chk(addr, 0);
        pull_n <= 1;
        run <= 0;
        $display("test target pull done");
        for (int i = 0; i < 8; i++) begin
            r = xs(r);
            rep <= r[0];
            core <= r[1];
            lowv <= r[2];
            prog <= r[3];
            cyc(3);
            chk(smode, r[0] ? r[1] : r[2]);
            chk(pmode, r[3]);
        end
        $display("test supply modes done");
        summarize();
    end
endmodule // cedp_loader_bench
`default_nettype wire

// ===== cedp_pkg.sv
// Package: constants for the configuration error detect and power-on block
package cedp_pkg;
    // Power-on delay, longest allowed, in microseconds
    localparam int unsigned POR_MAX_US = 200000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Longest time rounds down to whole cycles
    localparam int unsigned POR_CYCLES = (POR_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned IMAGE_BITS = 1024;
    localparam int unsigned ADDR_W = 20;
    // Supply mode encoding
    localparam logic MODE_5V0 = 1'h0;
    localparam logic MODE_3V3 = 1'h1;

    typedef enum logic [2:0] {
        CEDP_POR    = 3'h0,
        CEDP_IDLE   = 3'h1,
        CEDP_STREAM = 3'h2,
        CEDP_DONE   = 3'h3,
        CEDP_ERROR  = 3'h4
    } cedp_state_t;
endpackage

// ===== cedp_target.sv
// Model of the target's configuration controller: serial clock and done line
`timescale 1ns/1ps
`default_nettype none
module cedp_target (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic run_i,
    input wire logic [7:0] done_at_i,
    output logic sclk_o,
    output logic done_o,
    output logic [19:0] rises_o
);
    logic [1:0] ph_q;
    // Clock stands still unless running; four cycles per half period
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            ph_q <= 2'h0;
            sclk_o <= 1'h0;
            rises_o <= 20'h0;
            done_o <= 1'h0;
        end else if (run_i) begin
            ph_q <= ph_q + 2'h1;
            // Done one cycle after the counted rise, well before the next rise
            if (rises_o >= {12'h0, done_at_i}) done_o <= 1'h1;
            if (ph_q == 2'h3) begin
                sclk_o <= !sclk_o;
                rises_o <= rises_o + {19'h0, !sclk_o};
            end
        end
    end
endmodule // cedp_target
`default_nettype wire
